// >>> mesc_regs.vh
// Purpose: Offsets, field widths and limits of the error statistics counter block.
// Assumes: Word-aligned byte addresses on a plain register port, 8-bit address.
// Notes: Counter offsets and the control registers are local choices.
`ifndef MESC_REGS_VH
`define MESC_REGS_VH
`define MESC_ADDR_W 8
`define MESC_OFS_CARRIER 8'h00
`define MESC_OFS_RESOURCE 8'h04
`define MESC_OFS_OVERRUN 8'h08
`define MESC_OFS_SYMBOL 8'h0c
`define MESC_OFS_OVERLONG 8'h10
`define MESC_OFS_JABBER 8'h14
`define MESC_OFS_UNDERSIZE 8'h18
`define MESC_OFS_SQE 8'h1c
`define MESC_OFS_LENMIS 8'h20
`define MESC_OFS_CONFIG 8'h24
`define MESC_OFS_STATUS 8'h28
`define MESC_OFS_MASK 8'h2c
`define MESC_CFG_FULL_DUPLEX 0
`define MESC_CFG_BIG_FRAMES 8
`define MESC_CFG_LEN_CHECK 16
`define MESC_NUM_EVENTS 9
`define MESC_MIN_LEN 14'h0040
`define MESC_MAX_LEN 14'h05ee
`define MESC_MAX_LEN_BIG 14'h0600
`define MESC_TYPE_ID_MIN 16'h0600
`define MESC_BIT_TIME_NS 10
`define MESC_SQE_BITS 96
`define MESC_CLK_NS 10
`define MESC_SQE_CYCLES ((`MESC_SQE_BITS * `MESC_BIT_TIME_NS) / `MESC_CLK_NS)
`endif

// >>> mesc_counter.v
// Purpose: One saturating statistics counter with software load.
// Assumes: Increment is a one-cycle pulse.
// Notes: A software write takes priority over an increment in the same cycle.
`default_nettype none
module mesc_counter #(
  parameter WIDTH = 8
) (
  input wire clk_in,
  input wire rst_in,
  input wire inc_in,
  input wire load_in,
  input wire [WIDTH-1:0] load_value_in,
  output reg [WIDTH-1:0] count_out
);
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= {WIDTH{1'b0}};
    end else if (load_in) begin
      count_out <= load_value_in;
    end else if (inc_in && (count_out != {WIDTH{1'b1}})) begin
      count_out <= count_out + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // mesc_counter
`default_nettype wire

// >>> mesc_sqe_watch.v
// Purpose: Watches for col after the end of tx_en in half duplex.
// Assumes: Inputs are synchronous to the clock.
// Notes: Emits a one-cycle pulse when the window closes without col.
`default_nettype none
`include "mesc_regs.vh"
module mesc_sqe_watch (
  input wire clk_in,
  input wire rst_in,
  input wire half_duplex_in,
  input wire tx_en_in,
  input wire col_in,
  output reg sqe_error_out
);
  reg tx_en_prev;
  reg armed;
  reg [15:0] wait_count;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_en_prev <= 1'b0;
      armed <= 1'b0;
      wait_count <= 16'h0000;
      sqe_error_out <= 1'b0;
    end else begin
      tx_en_prev <= tx_en_in;
      sqe_error_out <= 1'b0;
      if (tx_en_prev && !tx_en_in && half_duplex_in) begin
        armed <= 1'b1;
        wait_count <= 16'h0000;
      end else if (armed) begin
        if (col_in || !half_duplex_in || tx_en_in) begin
          armed <= 1'b0;
        end else if (wait_count == (`MESC_SQE_CYCLES - 1)) begin
          armed <= 1'b0;
          sqe_error_out <= 1'b1;
        end else begin
          wait_count <= wait_count + 16'h0001;
        end
      end
    end
  end
endmodule // mesc_sqe_watch
`default_nettype wire

// >>> mesc_stats.v
// Summary of operation
// - Count transmit frames losing carrier sense.
// - Carrier sense errors counted only in half duplex.
// - Carrier sense error affects no other counter.
// - Count address-matched frames lacking receive buffer.
// - Count address-recognised frames lost to overrun.
// - Count received frames with rx_er asserted.
// - Valid-length symbol errors also flag FCS/alignment.
// - Overlong symbol-error frames also count as jabber.
// - Count clean frames above maximum length.
// - Count overlong frames with CRC/alignment/symbol errors.
// - Count clean frames shorter than 64 bytes.
// - Count missing col 96 bit times after tx_en.
// - Count frames shorter than their length field.
// - Length check only with configuration bit 16.
// - Type IDs and overlong frames skip length check.
// - Counters readable and writable; upper bits zero.
//
// Purpose: Error statistics counters of an Ethernet MAC with a register port.
// Assumes: Frame results arrive as one-cycle end-of-frame strobes with attributes.
// Notes: Read data appear the cycle after the read strobe.
`default_nettype none
`include "mesc_regs.vh"
module mesc_stats (
  input wire clk_in,
  input wire rst_in,
  input wire [7:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  output reg irq_out,
  output reg fcs_align_error_out,
  input wire tx_done_in,
  input wire tx_collision_in,
  input wire tx_underrun_in,
  input wire tx_en_in,
  input wire crs_in,
  input wire col_in,
  input wire rx_er_in,
  input wire rx_done_in,
  input wire rx_addr_match_in,
  input wire rx_no_buffer_in,
  input wire rx_overrun_in,
  input wire rx_crc_error_in,
  input wire rx_align_error_in,
  input wire [13:0] rx_length_in,
  input wire [15:0] rx_length_field_in
);
  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  reg [31:0] config_reg;
  reg [8:0] status;
  reg [8:0] mask;
  wire half_duplex = ~config_reg[`MESC_CFG_FULL_DUPLEX];
  wire big_frames = config_reg[`MESC_CFG_BIG_FRAMES];
  wire len_check = config_reg[`MESC_CFG_LEN_CHECK];

  // ---------------------------------------------------------------
  // Transmit carrier tracking
  // ---------------------------------------------------------------
  reg tx_active;
  reg crs_seen;
  reg crs_lost;
  reg rx_er_seen;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_active <= 1'b0;
      crs_seen <= 1'b0;
      crs_lost <= 1'b0;
    end else if (tx_en_in && !tx_active) begin
      tx_active <= 1'b1;
      crs_seen <= crs_in;
      crs_lost <= 1'b0;
    end else if (tx_active) begin
      if (crs_in) begin
        crs_seen <= 1'b1;
      end
      if (crs_seen && !crs_in) begin
        crs_lost <= 1'b1;
      end
      if (tx_done_in) begin
        tx_active <= 1'b0;
      end
    end
  end

  // Receive symbol error seen during the frame, cleared at frame end.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_er_seen <= 1'b0;
    end else if (rx_done_in) begin
      rx_er_seen <= 1'b0;
    end else if (rx_er_in) begin
      rx_er_seen <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Frame classification
  // ---------------------------------------------------------------
  wire [13:0] max_len = big_frames ? `MESC_MAX_LEN_BIG : `MESC_MAX_LEN;
  wire symbol_err = rx_er_seen | rx_er_in;
  wire too_long = rx_length_in > max_len;
  wire too_short = rx_length_in < `MESC_MIN_LEN;
  wire any_err = rx_crc_error_in | rx_align_error_in | symbol_err;
  wire is_type = rx_length_field_in >= `MESC_TYPE_ID_MIN;
  wire [8:0] ev;
  wire sqe_pulse;
  // Carrier sense error touches only its own counter.
  assign ev[0] = tx_done_in & half_duplex & ~tx_collision_in & ~tx_underrun_in &
                 (~crs_seen | crs_lost);
  assign ev[1] = rx_done_in & rx_addr_match_in & rx_no_buffer_in;
  assign ev[2] = rx_done_in & rx_addr_match_in & rx_overrun_in;
  assign ev[3] = rx_done_in & symbol_err;
  assign ev[4] = rx_done_in & too_long & ~any_err;
  assign ev[5] = rx_done_in & too_long & any_err;
  assign ev[6] = rx_done_in & too_short & ~any_err;
  assign ev[7] = sqe_pulse;
  assign ev[8] = rx_done_in & len_check & ~is_type & ~too_long &
                 ({2'b00, rx_length_in} < rx_length_field_in);

  mesc_sqe_watch u_sqe (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .half_duplex_in(half_duplex),
    .tx_en_in(tx_en_in),
    .col_in(col_in),
    .sqe_error_out(sqe_pulse)
  );

  // Symbol error on a valid-length frame goes to the FCS/alignment counters.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fcs_align_error_out <= 1'b0;
    end else begin
      fcs_align_error_out <= rx_done_in & symbol_err & ~too_short & ~too_long;
    end
  end

  // ---------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------
  wire [8:0] load;
  wire [7:0] cnt [0:8];
  wire [15:0] resource_count;
  assign load[0] = wr_in && (addr_in == `MESC_OFS_CARRIER);
  assign load[1] = wr_in && (addr_in == `MESC_OFS_RESOURCE);
  assign load[2] = wr_in && (addr_in == `MESC_OFS_OVERRUN);
  assign load[3] = wr_in && (addr_in == `MESC_OFS_SYMBOL);
  assign load[4] = wr_in && (addr_in == `MESC_OFS_OVERLONG);
  assign load[5] = wr_in && (addr_in == `MESC_OFS_JABBER);
  assign load[6] = wr_in && (addr_in == `MESC_OFS_UNDERSIZE);
  assign load[7] = wr_in && (addr_in == `MESC_OFS_SQE);
  assign load[8] = wr_in && (addr_in == `MESC_OFS_LENMIS);

  mesc_counter #(.WIDTH(16)) u_resource (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .inc_in(ev[1]),
    .load_in(load[1]),
    .load_value_in(wdata_in[15:0]),
    .count_out(resource_count)
  );
  assign cnt[1] = 8'h00;

  genvar gi;
  generate
    for (gi = 0; gi < `MESC_NUM_EVENTS; gi = gi + 1) begin : g_cnt
      if (gi != 1) begin : g_byte
        mesc_counter #(.WIDTH(8)) u_count (
          .clk_in(clk_in),
          .rst_in(rst_in),
          .inc_in(ev[gi]),
          .load_in(load[gi]),
          .load_value_in(wdata_in[7:0]),
          .count_out(cnt[gi])
        );
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Control, status, interrupt and read port
  // ---------------------------------------------------------------
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      config_reg <= 32'h00000000;
      mask <= 9'h000;
      status <= 9'h000;
      irq_out <= 1'b0;
    end else begin
      if (wr_in && (addr_in == `MESC_OFS_CONFIG)) begin
        config_reg <= wdata_in & 32'h00010101;
      end
      if (wr_in && (addr_in == `MESC_OFS_MASK)) begin
        mask <= wdata_in[8:0];
      end
      // A new event wins over a clear in the same cycle.
      if (wr_in && (addr_in == `MESC_OFS_STATUS)) begin
        status <= (status & ~wdata_in[8:0]) | ev;
      end else begin
        status <= status | ev;
      end
      irq_out <= |(status & mask);
    end
  end

  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    case (addr_in)
      `MESC_OFS_CARRIER: next_rdata = {24'h000000, cnt[0]};
      `MESC_OFS_RESOURCE: next_rdata = {16'h0000, resource_count};
      `MESC_OFS_OVERRUN: next_rdata = {24'h000000, cnt[2]};
      `MESC_OFS_SYMBOL: next_rdata = {24'h000000, cnt[3]};
      `MESC_OFS_OVERLONG: next_rdata = {24'h000000, cnt[4]};
      `MESC_OFS_JABBER: next_rdata = {24'h000000, cnt[5]};
      `MESC_OFS_UNDERSIZE: next_rdata = {24'h000000, cnt[6]};
      `MESC_OFS_SQE: next_rdata = {24'h000000, cnt[7]};
      `MESC_OFS_LENMIS: next_rdata = {24'h000000, cnt[8]};
      `MESC_OFS_CONFIG: next_rdata = config_reg;
      `MESC_OFS_STATUS: next_rdata = {23'h000000, status};
      `MESC_OFS_MASK: next_rdata = {23'h000000, mask};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= 32'h00000000;
    end
  end
endmodule // mesc_stats
`default_nettype wire

// >>> mesc_stats_sva.sv
// Purpose: Port assertions for the error statistics counters.
// Assumes: Config and mask follow the bus writes.
// Notes: Bound from the testbench file.
`default_nettype none
`include "mesc_regs.vh"
module mesc_stats_sva (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic irq_out,
  input wire logic fcs_align_error_out,
  input wire logic rx_done_in,
  input wire logic rx_er_in,
  input wire logic [13:0] rx_length_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic big;
  logic [8:0] msk;
  wire [13:0] lim = big ? `MESC_MAX_LEN_BIG : `MESC_MAX_LEN;
  wire sym_hit = rx_done_in && rx_er_in && rx_length_in >= `MESC_MIN_LEN
    && rx_length_in <= lim;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      big <= 1'b0;
      msk <= 9'h000;
    end else if (wr_in && addr_in == `MESC_OFS_CONFIG) begin
      big <= wdata_in[`MESC_CFG_BIG_FRAMES];
    end else if (wr_in && addr_in == `MESC_OFS_MASK) begin
      msk <= wdata_in[8:0];
    end
  end
  sequence wr_sym;
    wr_in && addr_in == `MESC_OFS_SYMBOL;
  endsequence
  sequence rd_sym;
    rd_in && addr_in == `MESC_OFS_SYMBOL;
  endsequence
  fcs_set_a: assert property (sym_hit |=> fcs_align_error_out)
    else $error("fcs pulse missing");
  fcs_cause_a: assert property (fcs_align_error_out |-> $past(sym_hit))
    else $error("fcs pulse without cause");
  read_idle_a: assert property (!rd_in |=> rdata_out == 32'h0)
    else $error("read data outside read");
  unmapped_read_a: assert property (
    rd_in && addr_in > `MESC_OFS_MASK |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  upper_byte_a: assert property (
    rd_in && addr_in <= `MESC_OFS_LENMIS && addr_in != `MESC_OFS_RESOURCE
    |=> rdata_out[31:8] == 24'h0) else $error("upper bits set");
  upper_half_a: assert property (
    rd_in && addr_in == `MESC_OFS_RESOURCE |=> rdata_out[31:16] == 16'h0)
    else $error("upper half set");
  load_value_a: assert property (
    wr_sym ##1 rd_sym |=> rdata_out == {24'h0, $past(wdata_in[7:0], 2)})
    else $error("loaded value not read back");
  irq_masked_a: assert property (msk == 9'h0 && $past(msk) == 9'h0 |-> !irq_out)
    else $error("interrupt while masked");
endmodule // mesc_stats_sva
`default_nettype wire

// >>> mesc_phy_model.sv
// Purpose: Media interface partner giving carrier sense and collision.
// Assumes: Levels change on the clock.
// Notes: A collision delay of zero means no collision test answer.
`default_nettype none
module mesc_phy_model (
  input wire logic clk_in,
  input wire logic tx_en_in,
  input wire logic [1:0] crs_mode_in,
  input wire logic [7:0] col_delay_in,
  output logic crs_out,
  output logic col_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] on_cnt = 8'h00;
  logic [7:0] off_cnt = 8'hff;
  always @(posedge clk_in) begin
    on_cnt <= tx_en_in ? on_cnt + 8'h01 : 8'h00;
    off_cnt <= tx_en_in ? 8'h00 : (off_cnt == 8'hff ? off_cnt : off_cnt + 8'h01);
  end
  // Carrier follows the transmitter, is absent, or drops after two cycles.
  assign crs_out = tx_en_in && (crs_mode_in == 2'h1 || (crs_mode_in == 2'h2 && on_cnt < 8'h02));
  assign col_out = col_delay_in != 8'h00 && off_cnt == col_delay_in;
endmodule // mesc_phy_model
`default_nettype wire

// >>> testbench.sv
// Purpose: Self-checking bench for the error statistics counters.
// Assumes: Counters follow the local offsets.
// Notes: Reads are checked from a queue of expected words.
`default_nettype none
`include "mesc_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, tx_done_in = 0, tx_collision_in = 0;
  logic tx_underrun_in = 0, tx_en_in = 0, rx_er_in = 0, rx_done_in = 0, rx_addr_match_in = 0;
  logic rx_no_buffer_in = 0, rx_overrun_in = 0, rx_crc_error_in = 0, rx_align_error_in = 0;
  logic irq_out, fcs_align_error_out, crs_in, col_in, rd_seen = 0, big = 0;
  logic [7:0] addr_in = 8'h00, col_delay = 8'h05;
  logic [31:0] wdata_in = 32'h0, rdata_out, rnd = 32'h80f6d4a0;
  logic [13:0] rx_length_in = 14'h0;
  logic [15:0] rx_length_field_in = 16'h0;
  logic [1:0] crs_mode = 2'h1;
  logic [31:0] exp_q[$];
  int failures = 0, n_tests = 0, e[9];
  mesc_stats uut (.*);
  mesc_phy_model phy (.clk_in, .tx_en_in, .crs_mode_in(crs_mode), .col_delay_in(col_delay),
    .crs_out(crs_in), .col_out(col_in));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] x);
    n_tests++;
    if (seen !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, x, seen);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wdata_in <= d;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    exp_q.push_back(x);
  endtask
  task automatic idle();
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
  endtask
  task automatic rx(input logic [13:0] n, input logic [15:0] fl, input logic [5:0] f,
    input logic [8:0] inc);
    @(posedge clk_in);
    {rx_er_in, rx_crc_error_in, rx_align_error_in, rx_addr_match_in, rx_no_buffer_in,
      rx_overrun_in} <= f;
    rx_length_in <= n;
    rx_length_field_in <= fl;
    rx_done_in <= 1'b1;
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    @(posedge clk_in);
    rx_done_in <= 1'b0;
    rx_er_in <= 1'b0;
    foreach (e[i]) e[i] += inc[i];
    #1;
    check("fcs", fcs_align_error_out, {31'h0, f[5] && n >= `MESC_MIN_LEN &&
      n <= (big ? `MESC_MAX_LEN_BIG : `MESC_MAX_LEN)});
  endtask
  task automatic tx(input logic [1:0] m, input logic [7:0] d, input logic c, input logic u,
    input logic [8:0] inc);
    @(posedge clk_in);
    crs_mode <= m;
    col_delay <= d;
    tx_en_in <= 1'b1;
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    tx_collision_in <= c;
    tx_underrun_in <= u;
    repeat (8) @(posedge clk_in);
    tx_done_in <= 1'b1;
    @(posedge clk_in);
    tx_done_in <= 1'b0;
    tx_en_in <= 1'b0;
    repeat (110) @(posedge clk_in);
    foreach (e[i]) e[i] += inc[i];
  endtask
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (rd_seen) check("rdata", rdata_out, exp_q.pop_front());
    rd_seen <= rd_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    print_verdict();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rnd = lfsr(rnd);
      bus(1'b1, {i[5:0], 2'b00}, rnd);
      rdx({i[5:0], 2'b00}, i == 1 ? {16'h0, rnd[15:0]} : {24'h0, rnd[7:0]});
    end
    rdx(8'h30, 32'h0);
    bus(1'b1, `MESC_OFS_SYMBOL, 32'hff);
    rx(14'h0064, 16'h0, 6'h20, 9'h000);
    rdx(`MESC_OFS_SYMBOL, 32'hff);
    for (int i = 0; i < 9; i++) bus(1'b1, {i[5:0], 2'b00}, 32'h0);
    bus(1'b1, `MESC_OFS_CONFIG, 32'h10000);
    rx(14'h0064, 16'h0064, 6'h20, 9'h008);
    rx(14'h05ef, 16'h05ff, 6'h20, 9'h028);
    rx(14'h05ef, 16'h05ff, 6'h10, 9'h020);
    rx(14'h05ef, 16'h05ff, 6'h00, 9'h010);
    rx(14'h05ee, 16'h0000, 6'h00, 9'h000);
    rx(14'h003f, 16'h0000, 6'h00, 9'h040);
    rx(14'h003f, 16'h0000, 6'h08, 9'h000);
    rx(14'h0064, 16'h00c8, 6'h00, 9'h100);
    rx(14'h0064, 16'h0600, 6'h00, 9'h000);
    rx(14'h0064, 16'h0000, 6'h06, 9'h002);
    rx(14'h0064, 16'h0000, 6'h02, 9'h000);
    rx(14'h0064, 16'h0000, 6'h05, 9'h004);
    bus(1'b1, `MESC_OFS_CONFIG, 32'h100);
    big = 1'b1;
    rx(14'h05fa, 16'h0000, 6'h20, 9'h008);
    rx(14'h05fa, 16'h0000, 6'h00, 9'h000);
    rx(14'h0601, 16'h0000, 6'h00, 9'h010);
    rx(14'h0064, 16'h00c8, 6'h00, 9'h000);
    tx(2'h0, 8'h05, 1'b0, 1'b0, 9'h001);
    tx(2'h2, 8'h05, 1'b0, 1'b0, 9'h001);
    tx(2'h1, 8'h05, 1'b0, 1'b0, 9'h000);
    tx(2'h0, 8'h05, 1'b1, 1'b0, 9'h000);
    tx(2'h0, 8'h05, 1'b0, 1'b1, 9'h000);
    tx(2'h1, 8'h00, 1'b0, 1'b0, 9'h080);
    tx(2'h1, 8'h5a, 1'b0, 1'b0, 9'h000);
    bus(1'b1, `MESC_OFS_CONFIG, 32'h101);
    tx(2'h0, 8'h00, 1'b0, 1'b0, 9'h000);
    check("irq", irq_out, 32'h0);
    bus(1'b1, `MESC_OFS_MASK, 32'h1ff);
    idle();
    repeat (2) @(posedge clk_in);
    #1;
    check("irq", irq_out, 32'h1);
    rdx(`MESC_OFS_STATUS, 32'h1ff);
    bus(1'b1, `MESC_OFS_STATUS, 32'h1ff);
    for (int i = 0; i < 9; i++) rdx({i[5:0], 2'b00}, e[i]);
    rdx(`MESC_OFS_STATUS, 32'h0);
    idle();
    repeat (2) @(posedge clk_in);
    #1;
    check("irq", irq_out, 32'h0);
    print_verdict();
  end
endmodule // testbench
bind mesc_stats mesc_stats_sva chk (.*);
`default_nettype wire
